// [core/aspbg_pkg.sv]
// shared constants and types of the serial port with baud timer
package aspbg_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TMR = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  // serial_control_reg bit positions
  localparam int CTRL_WIDTH = 7;
  localparam int CTRL_ONE = 6;
  localparam int CTRL_MCE = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TXDONE = 1;
  localparam int CTRL_RXDONE = 0;
  // timer control bit positions
  localparam int TMR_RUN = 0;
  localparam int TMR_SEL_LSB = 1;
  localparam int TMR_SEL_MSB = 3;
  localparam int TMR_IE = 4;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [4:0] TMR_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h1;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;
  // synchroniser lanes
  localparam int SYN_RXD = 0;
  localparam int SYN_OSC = 1;
  localparam int SYN_PIN = 2;
  // prescaler terminal counts: 4, then x3 for 12, then x4 for 48
  localparam logic [1:0] PRE_A_LAST = 2'h3;
  localparam logic [1:0] PRE_B_LAST = 2'h2;
  localparam logic [1:0] PRE_C_LAST = 2'h3;
  localparam logic [2:0] OSC_LAST = 3'h7;
  // last data bit index for 8-bit and 9-bit frames
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  // timer clock sources
  typedef enum logic [2:0] {
    SEL_CORE = 3'h0, SEL_DIV4 = 3'h1, SEL_DIV12 = 3'h2,
    SEL_DIV48 = 3'h3, SEL_OSC8 = 3'h4, SEL_PIN = 3'h5
  } aspbg_clksel_type;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_WAIT = 5'b00010, TX_START = 5'b00100,
    TX_DATA = 5'b01000, TX_STOP = 5'b10000
  } aspbg_tx_state_type;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } aspbg_rx_state_type;
endpackage

// [core/aspbg_cnt_if.sv]
// link between the port logic and one auto-reload baud counter
`timescale 1ns/1ps
interface aspbg_cnt_if #(parameter int W = 8);
  logic tick;
  logic load;
  logic force_rl;
  logic [W-1:0] load_val;
  logic [W-1:0] reload;
  logic [W-1:0] count;
  logic ovf;
  modport ctl (output tick, load, force_rl, load_val, reload,
               input count, ovf);
  modport cnt (input tick, load, force_rl, load_val, reload,
               output count, ovf);
endinterface

// [core/aspbg_baud_cnt.sv]
// auto-reload up counter used for the tx and hidden rx baud timers
`timescale 1ns/1ps
module aspbg_baud_cnt
  import aspbg_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  aspbg_cnt_if.cnt bus
);
  logic [W-1:0] count_r;

  // overflow when the counter wraps; a load or forced reload wins
  assign bus.ovf = bus.tick & (&count_r) & ~bus.load & ~bus.force_rl;
  assign bus.count = count_r;

  // R7: reload on overflow
  // R12: period is 256 minus reload ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (ce) begin
      if (bus.load) begin
        count_r <= bus.load_val;
      end else if (bus.force_rl) begin
        count_r <= bus.reload;
      end else if (bus.tick) begin
        count_r <= (&count_r) ? bus.reload : count_r + 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  chk_ovf_reload: // R7
  assert property (bus.ovf |=> count_r == $past(bus.reload))
    else $error("counter did not reload after overflow");
  chk_cnt_hold: // R10
  assert property (!bus.tick && !bus.load && !bus.force_rl
                   |=> $stable(count_r))
    else $error("counter moved while timer stopped");
endmodule

// [core/aspbg_clk_src.sv]
// timer clock source selector and prescaler, one tick per source edge
`timescale 1ns/1ps
module aspbg_clk_src
  import aspbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [2:0] sel,
  input wire logic osc_s,
  input wire logic pin_s,
  output logic tick
);
  logic [1:0] div_a_r;
  logic [1:0] div_b_r;
  logic [1:0] div_c_r;
  logic [2:0] osc_cnt_r;
  logic osc_prev_r;
  logic pin_prev_r;
  logic tick_a;
  logic tick_b;
  logic tick_c;
  logic osc_rise;
  logic pin_rise;

  // cascaded prescaler taps for /4, /12 and /48
  assign tick_a = div_a_r == PRE_A_LAST;
  assign tick_b = tick_a & (div_b_r == PRE_B_LAST);
  assign tick_c = tick_b & (div_c_r == PRE_C_LAST);
  assign osc_rise = osc_s & ~osc_prev_r;
  assign pin_rise = pin_s & ~pin_prev_r;

  // R14: six selectable sources
  // R15: oscillator only times the counter, core clock is untouched
  assign tick = (sel == SEL_CORE) |
                ((sel == SEL_DIV4) & tick_a) |
                ((sel == SEL_DIV12) & tick_b) |
                ((sel == SEL_DIV48) & tick_c) |
                ((sel == SEL_OSC8) & osc_rise & (osc_cnt_r == OSC_LAST)) |
                ((sel == SEL_PIN) & pin_rise);

  // counters run freely so a source switch needs no restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_a_r <= '0;
      div_b_r <= '0;
      div_c_r <= '0;
      osc_cnt_r <= '0;
      osc_prev_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else if (ce) begin
      div_a_r <= div_a_r + 1'b1;
      if (tick_a) begin
        div_b_r <= (div_b_r == PRE_B_LAST) ? 2'h0 : div_b_r + 1'b1;
      end
      if (tick_b) begin
        div_c_r <= div_c_r + 1'b1;
      end
      if (osc_rise) begin
        osc_cnt_r <= osc_cnt_r + 1'b1;
      end
      osc_prev_r <= osc_s;
      pin_prev_r <= pin_s;
    end
  end
endmodule

// [core/aspbg_top.sv]
// asynchronous serial port with apb registers and 8-bit baud timer
// Overview of operation
// R1: full-duplex port offering variable-rate 8-bit and 9-bit frame modes
// R2: a finished byte is buffered so the next reception can start
// R3: a write to the data location loads and starts transmission
// R4: a read of the data location returns the receive buffer only
// R5: interrupt requested when enabled and tx or rx done flag set
// R6: done flags stay set until software clears them
// R7: baud timer is an 8-bit counter reloading on overflow
// R8: tx clock from the timer count, rx from a hidden copy
// R9: each counter's overflows are halved to form the bit rate
// R10: hidden rx counter runs only with the timer, same reload byte
// R11: detected start bit forces a reload of the hidden rx counter
// R12: overflow rate is timer clock over 256 minus reload; baud half
// R13: software should use 8-bit reload mode, overflow at twice baud
// R14: timer clock from core, /4, /12, /48, oscillator /8 or pin
// R15: external oscillator may clock the timer while core runs on
// R16: 8-bit frame: start, eight data lsb first, stop into ninth bit
// R17: 9-bit frame adds ninth bit from register; rx ignores stop
// R18: load and flag only if flag clear and multiprocessor check passes
// R19: tx done flag set at the start of the stop bit
// R20: idle line high; start is a falling edge while rx enabled
`timescale 1ns/1ps
module aspbg_top
  import aspbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic ext_osc,
  input wire logic timer_ext_input,
  output logic irq
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic rxd_s;
  logic rxd_prev_r;
  logic acc;
  logic wr_en;
  logic rd_setup;
  logic hit_data;
  logic hit_ctrl;
  logic hit_tmr;
  logic hit_reload;
  logic hit_count;
  logic mapped;
  logic [7:0] rd_byte;
  logic [31:0] prdata_r;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_base;
  logic [7:0] ctrl_nxt;
  logic [4:0] tmr_r;
  logic [7:0] reload_r;
  logic [7:0] rx_buf_r;
  logic src_tick;
  logic cnt_tick;
  logic w9;
  logic [3:0] last_bit;
  logic tx_half_r;
  logic rx_half_r;
  logic tx_tick;
  logic rx_sample;
  logic tx_start;
  logic start_det;
  aspbg_tx_state_type tx_state_r;
  aspbg_tx_state_type tx_state_nxt;
  logic [8:0] tx_sh_r;
  logic [8:0] tx_sh_nxt;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic txd_r;
  logic txd_nxt;
  logic tx_set_done;
  aspbg_rx_state_type rx_state_r;
  aspbg_rx_state_type rx_state_nxt;
  logic [8:0] rx_sh_r;
  logic [8:0] rx_sh_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic rx_ninth;
  logic [7:0] rx_byte;
  logic rx_load;

  aspbg_cnt_if #(.W(8)) tx_bus ();
  aspbg_cnt_if #(.W(8)) rx_bus ();

  // pins cross two flops; only the second stage is read further on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= SYNC_RESET;
      sync_r <= SYNC_RESET;
      rxd_prev_r <= 1'b1;
    end else if (ce) begin
      meta_r <= {timer_ext_input, ext_osc, rxd};
      sync_r <= meta_r;
      rxd_prev_r <= sync_r[SYN_RXD];
    end
  end
  assign rxd_s = sync_r[SYN_RXD];

  // apb decode; zero wait states, unmapped offsets answer with pslverr
  assign acc = psel & penable;
  assign wr_en = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_data = paddr == OFS_DATA;
  assign hit_ctrl = paddr == OFS_CTRL;
  assign hit_tmr = paddr == OFS_TMR;
  assign hit_reload = paddr == OFS_RELOAD;
  assign hit_count = paddr == OFS_COUNT;
  assign mapped = hit_data | hit_ctrl | hit_tmr | hit_reload | hit_count;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_r;

  // R4: data offset reads the receive buffer, never the tx shifter
  assign rd_byte = hit_data ? rx_buf_r :
                   hit_ctrl ? ctrl_r :
                   hit_tmr ? {3'h0, tmr_r} :
                   hit_reload ? reload_r :
                   hit_count ? tx_bus.count : BYTE_RESET;

  // read data is latched in the setup cycle so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (ce && rd_setup) begin
      prdata_r <= {PAD_ZERO, rd_byte};
    end
  end

  // R6: flags clear only by software write
  // hardware set beats a same-cycle software clear
  assign ctrl_base = (wr_en & hit_ctrl) ? pwdata[7:0] : ctrl_r;
  assign ctrl_nxt = {ctrl_base[CTRL_WIDTH], 1'b1,
                     ctrl_base[CTRL_MCE:CTRL_TB8],
                     rx_load ? rx_ninth : ctrl_base[CTRL_RB8],
                     ctrl_base[CTRL_TXDONE] | tx_set_done,
                     ctrl_base[CTRL_RXDONE] | rx_load};

  // control, timer and reload registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      tmr_r <= TMR_RESET;
      reload_r <= BYTE_RESET;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      if (wr_en && hit_tmr) begin
        tmr_r <= pwdata[4:0];
      end
      if (wr_en && hit_reload) begin
        reload_r <= pwdata[7:0];
      end
    end
  end

  // R5: interrupt when enabled and either flag set
  assign irq = tmr_r[TMR_IE] & (ctrl_r[CTRL_TXDONE] | ctrl_r[CTRL_RXDONE]);

  aspbg_clk_src u_clk_src (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel(tmr_r[TMR_SEL_MSB:TMR_SEL_LSB]),
    .osc_s(sync_r[SYN_OSC]),
    .pin_s(sync_r[SYN_PIN]),
    .tick(src_tick)
  );

  // R8: tx clock from the visible count, rx from a hidden copy
  // R10: both count on the same run gate and reload byte
  assign cnt_tick = src_tick & tmr_r[TMR_RUN];
  assign tx_bus.tick = cnt_tick;
  assign tx_bus.load = wr_en & hit_count;
  assign tx_bus.force_rl = 1'b0;
  assign tx_bus.load_val = pwdata[7:0];
  assign tx_bus.reload = reload_r;
  assign rx_bus.tick = cnt_tick;
  assign rx_bus.load = 1'b0;
  // R11: start edge realigns the rx counter
  assign rx_bus.force_rl = start_det;
  assign rx_bus.load_val = BYTE_RESET;
  assign rx_bus.reload = reload_r;

  aspbg_baud_cnt #(.W(8)) u_tx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(tx_bus)
  );

  aspbg_baud_cnt #(.W(8)) u_rx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus(rx_bus)
  );

  // R9: bit clock is every second overflow
  // rx samples on the odd overflow, i.e. mid-bit after the forced reload
  assign tx_tick = tx_bus.ovf & tx_half_r;
  assign rx_sample = rx_bus.ovf & ~rx_half_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_half_r <= 1'b0;
      rx_half_r <= 1'b0;
    end else if (ce) begin
      tx_half_r <= tx_half_r ^ tx_bus.ovf;
      rx_half_r <= start_det ? 1'b0 : rx_half_r ^ rx_bus.ovf;
    end
  end

  // R1: frame width select picks the 8-bit or 9-bit mode
  assign w9 = ctrl_r[CTRL_WIDTH];
  assign last_bit = w9 ? LAST_BIT9 : LAST_BIT8;

  // R3: every data write (re)starts the transmitter
  // a write mid-frame aborts the frame in flight
  assign tx_start = wr_en & hit_data;

  // R16: start low, data lsb first, stop high
  // R17: ninth bit from its field in 9-bit mode
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    txd_nxt = txd_r;
    tx_set_done = 1'b0;
    if (tx_start) begin
      tx_state_nxt = TX_WAIT;
      tx_sh_nxt = {ctrl_r[CTRL_TB8], pwdata[7:0]};
      txd_nxt = 1'b1;
    end else if (tx_tick) begin
      case (tx_state_r)
        TX_WAIT: begin
          txd_nxt = 1'b0;
          tx_state_nxt = TX_START;
        end
        TX_START: begin
          txd_nxt = tx_sh_r[0];
          tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
          tx_cnt_nxt = 4'h0;
          tx_state_nxt = TX_DATA;
        end
        TX_DATA: begin
          if (tx_cnt_r == last_bit) begin
            // R19: flag rises as the stop bit begins
            txd_nxt = 1'b1;
            tx_set_done = 1'b1;
            tx_state_nxt = TX_STOP;
          end else begin
            txd_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
            tx_cnt_nxt = tx_cnt_r + 1'b1;
          end
        end
        TX_STOP: begin
          tx_state_nxt = TX_IDLE;
        end
        default: begin
          tx_state_nxt = TX_IDLE;
        end
      endcase
    end
  end

  // R20: idle high, start on falling edge with rx enabled
  assign start_det = (rx_state_r == RX_IDLE) & ctrl_r[CTRL_REN] &
                     rxd_prev_r & ~rxd_s;

  // R16: 8-bit mode stores the stop bit as ninth bit
  // R17: 9-bit mode stores the ninth data bit, stop ignored
  assign rx_ninth = w9 ? rx_sh_r[8] : rxd_s;
  assign rx_byte = w9 ? rx_sh_r[7:0] : rx_sh_r[8:1];

  // receiver; the shifter is separate from the buffer, so a new
  // frame can arrive while software still holds the previous byte
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_load = 1'b0;
    if (start_det) begin
      rx_state_nxt = RX_START;
    end else if (rx_sample) begin
      case (rx_state_r)
        RX_START: begin
          // a glitch that is high again mid-bit is no start
          rx_state_nxt = rxd_s ? RX_IDLE : RX_DATA;
          rx_cnt_nxt = 4'h0;
        end
        RX_DATA: begin
          rx_sh_nxt = {rxd_s, rx_sh_r[8:1]};
          rx_cnt_nxt = rx_cnt_r + 1'b1;
          if (rx_cnt_r == last_bit) begin
            rx_state_nxt = RX_STOP;
          end
        end
        RX_STOP: begin
          // R18: load only if flag clear and address check passes
          rx_load = ~ctrl_r[CTRL_RXDONE] &
                    (~ctrl_r[CTRL_MCE] | rx_ninth);
          rx_state_nxt = RX_IDLE;
        end
        default: begin
          rx_state_nxt = RX_IDLE;
        end
      endcase
    end
  end

  // serial state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      txd_r <= 1'b1;
      rx_state_r <= RX_IDLE;
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
    end else if (ce) begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      txd_r <= txd_nxt;
      rx_state_r <= rx_state_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end
  assign txd = txd_r;

  // R2: receive buffer holds the last accepted byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_r <= BYTE_RESET;
    end else if (ce && rx_load) begin
      rx_buf_r <= rx_byte;
    end
  end

  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  chk_tx_load_start: // R3
  assert property (tx_start |=> tx_state_r == TX_WAIT && txd_r)
    else $error("data write did not arm the transmitter");
  chk_rd_rx_buf: // R4
  assert property (rd_setup && hit_data
                   |=> prdata_r[7:0] == $past(rx_buf_r))
    else $error("data read did not return receive buffer");
  chk_irq_on_flag: // R5
  assert property (tx_set_done && tmr_r[TMR_IE] && !(wr_en && hit_tmr)
                   |=> irq)
    else $error("no interrupt after transmit done");
  chk_flag_sticky: // R6
  assert property (ctrl_r[CTRL_RXDONE] && !(wr_en && hit_ctrl)
                   |=> ctrl_r[CTRL_RXDONE])
    else $error("receive flag cleared without a write");
  chk_done_at_stop: // R19
  assert property (tx_state_r == TX_DATA && tx_tick && !tx_start &&
                   tx_cnt_r == last_bit
                   |=> ctrl_r[CTRL_TXDONE] && txd_r &&
                       tx_state_r == TX_STOP)
    else $error("transmit flag not set at stop bit");
  chk_rx_no_over: // R18
  assert property (rx_state_r == RX_STOP && rx_sample &&
                   ctrl_r[CTRL_RXDONE] |=> $stable(rx_buf_r))
    else $error("buffer overwritten while flag set");
  chk_rx_force: // R11
  assert property (start_det |=> rx_bus.count == $past(reload_r) &&
                   rx_state_r == RX_START && !rx_half_r)
    else $error("start edge did not reload rx counter");
  chk_start_low: // R16
  assert property (tx_state_r == TX_WAIT && tx_tick && !tx_start
                   |=> !txd_r && tx_state_r == TX_START)
    else $error("start bit not driven low");
endmodule

// [verification/aspbg_far_end.sv]
// remote serial transceiver model facing the txd and rxd pins
`timescale 1ns/1ps
module aspbg_far_end (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  int bit_cycles = 32;
  logic nine = 1'b0;
  logic [8:0] got = 9'h000;
  int frames = 0;
  // line rests high outside frames, like a pulled-up wire
  initial rxd = 1'b1;
  // start low, data lsb first, optional ninth bit, stop high
  task automatic send(input logic [7:0] d, input logic n, input logic b9);
    logic [10:0] f;
    int len;
    f = n ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
    len = n ? 11 : 10;
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (bit_cycles - 1) @(posedge pclk);
    end
  endtask
  // mid-bit sampling; a glitch shorter than half a bit is dropped
  always begin
    @(negedge txd);
    repeat (bit_cycles / 2) @(posedge pclk);
    if (txd === 1'b0) begin
      got = 9'h000;
      for (int i = 0; i < 9; i++) begin
        if (i < 8 || nine) begin
          repeat (bit_cycles) @(posedge pclk);
          got[i] = txd;
        end
      end
      frames++;
    end
  end
endmodule

// [verification/test_async_serial_port_baud_gen.sv]
// self-checking bench: apb master, far-end model and scenarios
`timescale 1ns/1ps
module test_async_serial_port_baud_gen
  import aspbg_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic txd;
  logic irq;
  logic [31:0] rv;
  logic re;
  logic [1:0] src_drv = 2'b00;
  int bad_count = 0;
  int tests_run = 0;

  // oscillator and timer pins rest low until the source scenario pulses
  aspbg_top aspbg_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .ext_osc(src_drv[0]),
    .timer_ext_input(src_drv[1]), .irq(irq));
  aspbg_far_end aspbg_far_end_inst (.pclk(pclk), .txd(txd), .rxd(rxd));

  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, exp);
      bad_count++;
    end
  endtask

  // apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string msg);
    apb(1'b0, a, 32'h0000_0000);
    check(rv, e, msg);
  endtask

  // bounded wait for the far end to finish capturing a frame
  task automatic send_wait(input logic [7:0] d);
    int n0;
    n0 = aspbg_far_end_inst.frames;
    apb(1'b1, OFS_DATA, {24'h00_0000, d});
    for (int i = 0; i < 2000; i++) begin
      if (aspbg_far_end_inst.frames != n0) break;
      @(posedge pclk);
    end
    // the done flag rises half a bit after the last data sample
    repeat (aspbg_far_end_inst.bit_cycles) @(posedge pclk);
    check(aspbg_far_end_inst.frames - n0, 32'h0000_0001, "frame seen");
  endtask

  // pulses on the oscillator (bit 0) or timer pin (bit 1), then sync time
  task automatic pulses(input logic [1:0] m, input int n);
    repeat (n) begin
      src_drv <= m;
      repeat (2) @(posedge pclk);
      src_drv <= 2'b00;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  // fixed span: the sent 10- or 11-bit frame plus two bits of margin at the current bit period
  task automatic frame_in(input logic [7:0] d, input logic n,
                          input logic b9);
    aspbg_far_end_inst.send(d, n, b9);
    repeat (aspbg_far_end_inst.bit_cycles * 2) @(posedge pclk);
  endtask

  task automatic t_reset;
    rd_chk(OFS_CTRL, 32'h0000_0040, "ctrl reset");
    rd_chk(OFS_TMR, 32'h0000_0000, "tmr reset");
    rd_chk(OFS_RELOAD, 32'h0000_0000, "reload reset");
    rd_chk(OFS_COUNT, 32'h0000_0000, "count reset");
    rd_chk(OFS_DATA, 32'h0000_0000, "data reset");
    apb(1'b1, 8'h14, 32'h0000_00FF);
    rd_chk(8'h14, 32'h0000_0000, "unmapped read");
    check({31'h0, re}, 32'h0000_0001, "unmapped error");
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0040, "ctrl bit6 fixed");
    $display("test reset done");
  endtask

  task automatic t_tx8;
    // reload mode, overflows at twice the wanted bit rate
    apb(1'b1, OFS_RELOAD, 32'h0000_00F0);
    apb(1'b1, OFS_TMR, 32'h0000_0011);
    send_wait(8'hA5);
    check({23'h0, aspbg_far_end_inst.got}, 32'h0000_00A5, "tx byte");
    rd_chk(OFS_CTRL, 32'h0000_0042, "tx done flag");
    check({31'h0, irq}, 32'h0000_0001, "irq on tx done");
    rd_chk(OFS_CTRL, 32'h0000_0042, "flag kept");
    apb(1'b1, OFS_TMR, 32'h0000_0001);
    // irq follows the enable bit only after the write edge has settled
    @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0040, "flag cleared");
    $display("test tx8 done");
  endtask

  task automatic t_rx8;
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    frame_in(8'h3C, 1'b0, 1'b1);
    rd_chk(OFS_CTRL, 32'h0000_0055, "rx done, stop bit");
    rd_chk(OFS_DATA, 32'h0000_003C, "rx buffer not tx");
    frame_in(8'hC3, 1'b0, 1'b1);
    rd_chk(OFS_DATA, 32'h0000_003C, "kept while flag set");
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    frame_in(8'h0F, 1'b0, 1'b1);
    rd_chk(OFS_DATA, 32'h0000_000F, "second byte");
    $display("test rx8 done");
  endtask

  task automatic t_nine;
    apb(1'b1, OFS_CTRL, 32'h0000_00B0);
    frame_in(8'h5A, 1'b1, 1'b0);
    rd_chk(OFS_CTRL, 32'h0000_00F0, "mce refuses");
    frame_in(8'h96, 1'b1, 1'b1);
    rd_chk(OFS_CTRL, 32'h0000_00F5, "ninth stored");
    rd_chk(OFS_DATA, 32'h0000_0096, "9-bit data");
    apb(1'b1, OFS_CTRL, 32'h0000_0088);
    aspbg_far_end_inst.nine = 1'b1;
    send_wait(8'h81);
    check({23'h0, aspbg_far_end_inst.got}, 32'h0000_0181, "tx ninth");
    aspbg_far_end_inst.nine = 1'b0;
    $display("test nine done");
  endtask

  task automatic t_gate;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    frame_in(8'h11, 1'b0, 1'b1);
    rd_chk(OFS_CTRL, 32'h0000_0040, "rx disabled");
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    apb(1'b1, OFS_TMR, 32'h0000_0000);
    frame_in(8'h22, 1'b0, 1'b1);
    rd_chk(OFS_CTRL, 32'h0000_0050, "timer stopped");
    $display("test gate done");
  endtask

  // /4 source, reload 0xFE: overflow 8 pclk, bit period 16 pclk
  task automatic t_div4;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_RELOAD, 32'h0000_00FE);
    apb(1'b1, OFS_TMR, 32'h0000_0003);
    aspbg_far_end_inst.bit_cycles = 16;
    send_wait(8'h69);
    check({23'h0, aspbg_far_end_inst.got}, 32'h0000_0069, "div4 baud");
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    frame_in(8'hE7, 1'b0, 1'b1);
    rd_chk(OFS_DATA, 32'h0000_00E7, "div4 rx");
    $display("test div4 done");
  endtask

  // pin source: one tick per rise; oscillator source: one per eight rises
  task automatic t_src;
    apb(1'b1, OFS_TMR, 32'h0000_000B);
    apb(1'b1, OFS_COUNT, 32'h0000_0010);
    pulses(2'b10, 5);
    rd_chk(OFS_COUNT, 32'h0000_0015, "pin source");
    apb(1'b1, OFS_TMR, 32'h0000_0009);
    apb(1'b1, OFS_COUNT, 32'h0000_0020);
    pulses(2'b01, 16);
    rd_chk(OFS_COUNT, 32'h0000_0022, "osc source");
    $display("test src done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_tx8;
    t_rx8;
    t_nine;
    t_gate;
    t_div4;
    t_src;
    stop_test;
  end
endmodule
